// >>> rtl/irsu_pkg.sv
// package: constants, register map and helpers of the rotate and shift unit
`default_nettype none
package irsu_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_SOURCE = 8'h00;
  localparam logic [7:0] OFF_AMOUNT = 8'h04;
  localparam logic [7:0] OFF_DEST = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_EXC = 8'h10;
  localparam logic [7:0] OFF_COND = 8'h14;
  // ==========================================================
  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_REC_BIT = 3;
  localparam int CTRL_IMM_LSB = 4;
  localparam int CTRL_MBEGIN_LSB = 9;
  localparam int CTRL_MEND_LSB = 14;
  localparam int CTRL_W = 19;
  // ==========================================================
  // operation codes
  localparam logic [2:0] OP_ROT_REG_MASK = 3'h0;
  localparam logic [2:0] OP_ROT_IMM_MASK = 3'h1;
  localparam logic [2:0] OP_ROT_IMM_INS = 3'h2;
  localparam logic [2:0] OP_SHL = 3'h3;
  localparam logic [2:0] OP_SHR = 3'h4;
  localparam logic [2:0] OP_SRA_IMM = 3'h5;
  localparam logic [2:0] OP_SRA_REG = 3'h6;
  // ==========================================================
  // fixed-point exception bits and condition field bits
  localparam int EXC_CARRY_BIT = 0;
  localparam int EXC_OVF_BIT = 1;
  localparam int EXC_SUMOVF_BIT = 2;
  localparam int COND_LT_BIT = 3;
  localparam int COND_GT_BIT = 2;
  localparam int COND_EQ_BIT = 1;
  localparam int COND_SO_BIT = 0;
  // ==========================================================
  // reset values
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [18:0] CTRL_RST = 19'h0_0000;
  localparam logic [2:0] EXC_RST = 3'h0;
  localparam logic [3:0] COND_RST = 4'h0;

  // signed compare of a result against zero, plus summary overflow
  function automatic logic [3:0] irsu_cond_of(input logic [31:0] r, input logic so);
    logic [3:0] c;
    c = 4'h0;
    c[COND_LT_BIT] = r[31];
    c[COND_GT_BIT] = ~r[31] & (|r);
    c[COND_EQ_BIT] = ~(|r);
    c[COND_SO_BIT] = so;
    return c;
  endfunction : irsu_cond_of
endpackage : irsu_pkg
`default_nettype wire

// >>> rtl/irsu_mask_gen.sv
// mask generator: ones from mask_begin through mask_end, msb-first numbering
`default_nettype none
module irsu_mask_gen (
  input wire logic [4:0] mask_begin,
  input wire logic [4:0] mask_end,
  output logic [31:0] mask
);
  // ==========================================================
  // position i counts from the msb, so vector bit is 31-i
  always_comb begin
    mask = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (mask_begin <= mask_end) begin
        mask[31-i] = (5'(i) >= mask_begin) && (5'(i) <= mask_end); // [RULE_14]
      end else begin
        mask[31-i] = (5'(i) >= mask_begin) || (5'(i) <= mask_end); // [RULE_14]
      end
    end
  end
endmodule : irsu_mask_gen
`default_nettype wire

// >>> rtl/irsu_shift_core.sv
// shift core: circular rotate, logical shifts and arithmetic right shift with carry
`default_nettype none
module irsu_shift_core (
  input wire logic [31:0] src,
  input wire logic [5:0] amt,
  output logic [31:0] rot,
  output logic [31:0] shl,
  output logic [31:0] shr,
  output logic [31:0] sra,
  output logic sra_carry
);
  // ==========================================================
  // rotate uses only the low five bits; shifts use all six
  wire logic [4:0] n = amt[4:0];
  wire logic [5:0] back = 6'h20 - {1'b0, n};
  wire logic [31:0] lost_mask = ~(32'hFFFF_FFFF << n);
  wire logic any_lost = amt[5] ? (|src) : (|(src & lost_mask));

  // msb-first numbering: left means toward the msb, bits leaving the msb come back at the lsb
  assign rot = (src << n) | (src >> back); // [RULE_13]
  assign shl = amt[5] ? 32'h0000_0000 : (src << n); // [RULE_03] [RULE_04]
  assign shr = amt[5] ? 32'h0000_0000 : (src >> n); // [RULE_05] [RULE_04]
  assign sra = amt[5] ? {32{src[31]}} : 32'($signed(src) >>> n); // [RULE_08] [RULE_10]
  // zero amount loses nothing, so carry clears and data passes unchanged
  assign sra_carry = src[31] & any_lost; // [RULE_06] [RULE_08] [RULE_07] [RULE_09]
endmodule : irsu_shift_core
`default_nettype wire

// >>> rtl/irsu_rot_shift_unit.sv
// integer rotate and shift unit with apb register access
//
// Function
// RULE_01: rotate-and-mask by register rotates the source left by amount bits 4..0 and ANDs with the mask.
// RULE_02: rotate-then-insert rotates by the immediate count and replaces only destination bits under the mask.
// RULE_03: logical left shift uses the six-bit amount, loses bits off the top and fills zeros at the bottom.
// RULE_04: logical shifts give zero whenever the top bit of the six-bit amount is set.
// RULE_05: logical right shift uses the six-bit amount and fills zeros from the top.
// RULE_06: arithmetic shift by immediate sign-extends and sets carry only for a negative source losing a one.
// RULE_07: arithmetic shift by immediate zero copies the source and clears carry.
// RULE_08: arithmetic shift by register uses six bits, fills with sign, sets carry only for negative losing ones.
// RULE_09: arithmetic shift by register with zero amount copies the source and clears carry.
// RULE_10: arithmetic shift by register with the amount top bit set fills all bits with the sign.
// RULE_11: a record flag selects condition update; without it the condition field is kept.
// RULE_12: for arithmetic shift by register the condition comes from the value written to the destination.
// RULE_13: rotation is circular over 32 bits, bits leaving the msb re-enter at the lsb.
// RULE_14: the mask is ones from begin through end inclusive, wrapping when begin exceeds end.
// RULE_15: overflow and summary overflow are never touched; only arithmetic shifts touch carry.
// RULE_16: with condition update every operation sets the condition field from the final destination.
// RULE_17: the condition field holds less-than, greater-than, equal against zero and a copy of summary overflow.
`default_nettype none
module irsu_rot_shift_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] dest_value,
  output logic shift_out_flag,
  output logic [3:0] result_cond_field
);
  // ==========================================================
  // registers
  logic [31:0] source_reg;
  logic [31:0] amount_reg;
  logic [31:0] dest_reg;
  logic [18:0] ctrl_reg;
  logic [2:0] fixed_point_exception_reg;
  logic [3:0] result_cond_field_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // ==========================================================
  // apb decode: no wait state, answer in the cycle after setup
  wire logic setup = psel & ~penable;
  wire logic done = psel & penable & pready_reg;
  wire logic wr = done & pwrite;
  wire logic sel_source = paddr == irsu_pkg::OFF_SOURCE;
  wire logic sel_amount = paddr == irsu_pkg::OFF_AMOUNT;
  wire logic sel_dest = paddr == irsu_pkg::OFF_DEST;
  wire logic sel_ctrl = paddr == irsu_pkg::OFF_CTRL;
  wire logic sel_exc = paddr == irsu_pkg::OFF_EXC;
  wire logic sel_cond = paddr == irsu_pkg::OFF_COND;
  wire logic addr_hit = sel_source | sel_amount | sel_dest | sel_ctrl | sel_exc | sel_cond;
  wire logic [31:0] rd_mux =
    sel_source ? source_reg :
    sel_amount ? amount_reg :
    sel_dest ? dest_reg :
    sel_ctrl ? {13'h0000, ctrl_reg} :
    sel_exc ? {29'h0000_0000, fixed_point_exception_reg} :
    sel_cond ? {28'h000_0000, result_cond_field_reg} : 32'h0000_0000;

  // ==========================================================
  // operation fields, taken from the control word being written
  wire logic [2:0] op = pwdata[irsu_pkg::CTRL_OP_LSB +: 3];
  wire logic rec = pwdata[irsu_pkg::CTRL_REC_BIT];
  wire logic [4:0] imm_rotate_count = pwdata[irsu_pkg::CTRL_IMM_LSB +: 5];
  wire logic [4:0] mask_begin = pwdata[irsu_pkg::CTRL_MBEGIN_LSB +: 5];
  wire logic [4:0] mask_end = pwdata[irsu_pkg::CTRL_MEND_LSB +: 5];
  wire logic op_valid = op != 3'h7;
  wire logic op_fire = wr & sel_ctrl & op_valid;
  wire logic is_sra = (op == irsu_pkg::OP_SRA_IMM) | (op == irsu_pkg::OP_SRA_REG);
  wire logic use_imm = (op == irsu_pkg::OP_ROT_IMM_MASK) | (op == irsu_pkg::OP_ROT_IMM_INS) |
                       (op == irsu_pkg::OP_SRA_IMM);
  // rotate by register sees only bits 4..0 because the core masks them
  wire logic [5:0] amt_sel = use_imm ? {1'b0, imm_rotate_count} : amount_reg[5:0]; // [RULE_01] [RULE_03]

  logic [31:0] mask_w;
  logic [31:0] rot_w;
  logic [31:0] shl_w;
  logic [31:0] shr_w;
  logic [31:0] sra_w;
  logic sra_carry_w;

  irsu_mask_gen u_mask (
    .mask_begin(mask_begin),
    .mask_end(mask_end),
    .mask(mask_w)
  );

  irsu_shift_core u_core (
    .src(source_reg),
    .amt(amt_sel),
    .rot(rot_w),
    .shl(shl_w),
    .shr(shr_w),
    .sra(sra_w),
    .sra_carry(sra_carry_w)
  );

  // ==========================================================
  // result selection
  wire logic [31:0] rot_and = rot_w & mask_w; // [RULE_01]
  wire logic [31:0] rot_ins = (rot_w & mask_w) | (dest_reg & ~mask_w); // [RULE_02]
  wire logic [31:0] dest_next =
    (op == irsu_pkg::OP_ROT_REG_MASK) ? rot_and :
    (op == irsu_pkg::OP_ROT_IMM_MASK) ? rot_and :
    (op == irsu_pkg::OP_ROT_IMM_INS) ? rot_ins :
    (op == irsu_pkg::OP_SHL) ? shl_w :
    (op == irsu_pkg::OP_SHR) ? shr_w : sra_w;
  // condition built from the exact value that lands in the destination
  wire logic [3:0] cond_next =
    irsu_pkg::irsu_cond_of(dest_next, fixed_point_exception_reg[irsu_pkg::EXC_SUMOVF_BIT]); // [RULE_12] [RULE_16] [RULE_17]

  // ==========================================================
  // bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= irsu_pkg::DATA_RST;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~addr_hit;
      prdata_reg <= (setup & ~pwrite) ? rd_mux : irsu_pkg::DATA_RST;
    end
  end

  // ==========================================================
  // operand and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_reg <= irsu_pkg::DATA_RST;
      amount_reg <= irsu_pkg::DATA_RST;
      ctrl_reg <= irsu_pkg::CTRL_RST;
    end else begin
      if (wr & sel_source) begin
        source_reg <= pwdata;
      end
      if (wr & sel_amount) begin
        amount_reg <= pwdata;
      end
      if (wr & sel_ctrl) begin
        ctrl_reg <= pwdata[irsu_pkg::CTRL_W-1:0];
      end
    end
  end

  // ==========================================================
  // destination, flags and condition field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_reg <= irsu_pkg::DATA_RST;
      fixed_point_exception_reg <= irsu_pkg::EXC_RST;
      result_cond_field_reg <= irsu_pkg::COND_RST;
    end else begin
      if (op_fire) begin
        dest_reg <= dest_next;
      end else if (wr & sel_dest) begin
        dest_reg <= pwdata;
      end
      // only arithmetic shifts and exception register writes move carry; overflow bits stay with software
      if (wr & sel_exc) begin
        fixed_point_exception_reg <= pwdata[2:0];
      end else if (op_fire & is_sra) begin
        fixed_point_exception_reg[irsu_pkg::EXC_CARRY_BIT] <= sra_carry_w; // [RULE_15] [RULE_06] [RULE_08]
      end
      if (op_fire & rec) begin
        result_cond_field_reg <= cond_next; // [RULE_11] [RULE_16]
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dest_value = dest_reg;
  assign shift_out_flag = fixed_point_exception_reg[irsu_pkg::EXC_CARRY_BIT];
  assign result_cond_field = result_cond_field_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fire(logic [2:0] code);
    op_fire && op == code;
  endsequence

  AST_ROT_REG_FULL_MASK: assert property ( // [RULE_01]
    s_fire(irsu_pkg::OP_ROT_REG_MASK) ##0 (mask_begin == 5'h00 && mask_end == 5'h1F && amount_reg[4:0] == 5'h01)
    |=> dest_reg == {$past(source_reg[30:0]), $past(source_reg[31])})
    else $error("rotate by one with full mask wrong");
  AST_INSERT_KEEPS: assert property ( // [RULE_02]
    s_fire(irsu_pkg::OP_ROT_IMM_INS) |=> ((dest_reg ^ $past(dest_reg)) & ~$past(mask_w)) == 32'h0000_0000)
    else $error("insert changed bits outside mask");
  AST_SHL_ONE: assert property ( // [RULE_03]
    s_fire(irsu_pkg::OP_SHL) ##0 (amount_reg[5:0] == 6'h01) |=> dest_reg == {$past(source_reg[30:0]), 1'b0})
    else $error("left shift by one wrong");
  AST_LOGIC_ZERO: assert property ( // [RULE_04]
    (op_fire && (op == irsu_pkg::OP_SHL || op == irsu_pkg::OP_SHR) && amount_reg[5]) |=> dest_reg == 32'h0000_0000)
    else $error("logical shift with large amount not zero");
  AST_SHR_ONE: assert property ( // [RULE_05]
    s_fire(irsu_pkg::OP_SHR) ##0 (amount_reg[5:0] == 6'h01) |=> dest_reg == {1'b0, $past(source_reg[31:1])})
    else $error("right shift by one wrong");
  AST_SRAI_CARRY: assert property ( // [RULE_06]
    s_fire(irsu_pkg::OP_SRA_IMM) ##0 (imm_rotate_count == 5'h01)
    |=> shift_out_flag == ($past(source_reg[31]) & $past(source_reg[0])) && dest_reg[31] == $past(source_reg[31]))
    else $error("arithmetic immediate carry wrong");
  AST_SRAI_ZERO: assert property ( // [RULE_07]
    s_fire(irsu_pkg::OP_SRA_IMM) ##0 (imm_rotate_count == 5'h00) |=> dest_reg == $past(source_reg) && !shift_out_flag)
    else $error("arithmetic immediate zero count wrong");
  AST_SRA_ZERO: assert property ( // [RULE_09]
    s_fire(irsu_pkg::OP_SRA_REG) ##0 (amount_reg[5:0] == 6'h00) |=> dest_reg == $past(source_reg) && !shift_out_flag)
    else $error("arithmetic register zero amount wrong");
  AST_SRA_FILL: assert property ( // [RULE_10]
    s_fire(irsu_pkg::OP_SRA_REG) ##0 amount_reg[5] |=> dest_reg == {32{$past(source_reg[31])}})
    else $error("arithmetic large amount not sign filled");
  AST_NO_REC_KEEP: assert property ( // [RULE_11]
    !(op_fire && rec) |=> $stable(result_cond_field_reg))
    else $error("condition field changed without record");
  AST_COND_FROM_DEST: assert property ( // [RULE_12]
    (op_fire && rec) |=> result_cond_field_reg[irsu_pkg::COND_EQ_BIT] == (dest_reg == 32'h0000_0000)
      && result_cond_field_reg[irsu_pkg::COND_LT_BIT] == dest_reg[31])
    else $error("condition field does not match destination");
  AST_MASK_NONZERO: assert property ( // [RULE_14]
    mask_w[31 - mask_begin] && mask_w[31 - mask_end])
    else $error("mask ends not set");
  AST_OVF_KEEP: assert property ( // [RULE_15]
    !(wr && sel_exc) |=> $stable(fixed_point_exception_reg[2:1]))
    else $error("overflow bits changed by an operation");
  AST_CARRY_KEEP: assert property ( // [RULE_15]
    !(wr && sel_exc) && !(op_fire && is_sra) |=> $stable(shift_out_flag))
    else $error("carry changed by a non arithmetic operation");

  // ==========================================================
  // result checks not tied to one amount: vacated bits for amounts below 32, sign, carry, condition
  AST_ROT_REG_MASK_OUT: assert property ( // [RULE_01]
    s_fire(irsu_pkg::OP_ROT_REG_MASK) |=> (dest_reg & ~$past(mask_w)) == 32'h0000_0000)
    else $error("rotate by register kept bits outside mask");
  AST_ROT_IMM_MASK_OUT: assert property ( // [RULE_14]
    s_fire(irsu_pkg::OP_ROT_IMM_MASK) |=> (dest_reg & ~$past(mask_w)) == 32'h0000_0000)
    else $error("rotate by immediate kept bits outside mask");
  AST_SHL_VACATED: assert property ( // [RULE_03]
    s_fire(irsu_pkg::OP_SHL) ##0 !amount_reg[5]
    |=> (dest_reg & ~(32'hFFFF_FFFF << $past(amount_reg[4:0]))) == 32'h0000_0000)
    else $error("left shift vacated bits not zero");
  AST_SHR_VACATED: assert property ( // [RULE_05]
    s_fire(irsu_pkg::OP_SHR) ##0 !amount_reg[5]
    |=> (dest_reg & ~(32'hFFFF_FFFF >> $past(amount_reg[4:0]))) == 32'h0000_0000)
    else $error("right shift vacated bits not zero");
  AST_SRAI_SIGN: assert property ( // [RULE_06]
    s_fire(irsu_pkg::OP_SRA_IMM) |=> dest_reg[31] == $past(source_reg[31]))
    else $error("arithmetic immediate lost the sign");
  AST_SRA_SIGN: assert property ( // [RULE_08]
    s_fire(irsu_pkg::OP_SRA_REG) |=> dest_reg[31] == $past(source_reg[31]))
    else $error("arithmetic register lost the sign");
  AST_SRA_POS_NO_CARRY: assert property ( // [RULE_08]
    s_fire(irsu_pkg::OP_SRA_REG) ##0 !source_reg[31] |=> !shift_out_flag)
    else $error("carry set for a positive source");
  AST_COND_GT: assert property ( // [RULE_17]
    (op_fire && rec) |=> result_cond_field_reg[irsu_pkg::COND_GT_BIT]
      == (!dest_reg[31] && dest_reg != 32'h0000_0000))
    else $error("greater than bit wrong");
  AST_COND_SO_COPY: assert property ( // [RULE_17]
    (op_fire && rec) |=> result_cond_field_reg[irsu_pkg::COND_SO_BIT]
      == fixed_point_exception_reg[irsu_pkg::EXC_SUMOVF_BIT])
    else $error("summary overflow copy wrong");
  AST_NO_OP_KEEP: assert property (
    (wr && sel_ctrl && !op_valid) |=> $stable(dest_reg) && $stable(result_cond_field_reg))
    else $error("unused operation code changed results");
  AST_DEST_IDLE_KEEP: assert property (
    !op_fire && !(wr && sel_dest) |=> $stable(dest_reg))
    else $error("destination changed with nothing issued");

  // ==========================================================
  // bus answer checks: no wait state, answer strobes last one cycle
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  AST_READY_AFTER_SETUP: assert property (
    s_setup |=> s_answer)
    else $error("no single cycle answer after setup");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  AST_ERR_ONLY_UNMAPPED: assert property (
    s_setup ##0 addr_hit |=> !pslverr)
    else $error("error on a mapped address");
  AST_RDATA_IDLE_ZERO: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data not zero outside an answer");
  AST_WRITE_RDATA_ZERO: assert property (
    s_setup ##0 pwrite |=> prdata == 32'h0000_0000)
    else $error("read data shown during a write");
endmodule : irsu_rot_shift_unit
`default_nettype wire

// >>> tb/irsu_issue_model.sv
// apb issuing model standing in for the core's decode and register file
`default_nettype none
module irsu_issue_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // ==========================================================
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // waits as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines carry inverted values so stale data never looks live
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : irsu_issue_model
`default_nettype wire

// >>> tb/test_integer_rotate_shift_unit.sv
// self-checking bench for the rotate and shift unit
`default_nettype none
module test_integer_rotate_shift_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, carry;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dest_value, m_dest;
  logic [3:0] cond, m_cond;
  logic [2:0] m_exc;
  int num_errors;
  int total_checks;

  irsu_rot_shift_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dest_value(dest_value), .shift_out_flag(carry), .result_cond_field(cond));
  irsu_issue_model i_issue (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ==========================================================
  // checking helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    i_issue.xfer(1'b1, a, d, rd, e);
  endtask : wr
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] rd;
    logic e;
    i_issue.xfer(1'b0, a, 32'h0000_0000, rd, e);
    check(what, exp, rd);
    check({what, " err"}, {31'h0, err}, {31'h0, e});
  endtask : rd_chk
  // msb-first numbering: position p is vector bit 31-p
  function automatic logic [31:0] mk(input int b, input int e);
    for (int p = 0; p < 32; p++)
      mk[31 - p] = (b <= e) ? (p >= b && p <= e) : (p >= b || p <= e);
  endfunction : mk
  function automatic logic [31:0] rotl(input logic [31:0] x, input int n);
    return (x << n) | (x >> (32 - n));
  endfunction : rotl
  // ==========================================================
  // one operation: load operands, launch through the control word, compare
  task automatic run_op(input logic [2:0] op, input logic rec, input logic [31:0] src, input logic [5:0] amt,
                        input logic [31:0] dst, input logic [4:0] imm, input logic [4:0] mbeg,
                        input logic [4:0] mend, input logic [2:0] xr);
    logic [31:0] r, m;
    logic c;
    int n;
    m = mk(int'(mbeg), int'(mend));
    n = (op == irsu_pkg::OP_SRA_IMM) ? int'(imm) : int'(amt);
    c = src[31] && ((src & ~(32'hFFFF_FFFF << n)) != 32'h0000_0000);
    m_exc = xr;
    case (op)
      3'h0: r = rotl(src, int'(amt[4:0])) & m;
      3'h1: r = rotl(src, int'(imm)) & m;
      3'h2: r = (rotl(src, int'(imm)) & m) | (dst & ~m);
      3'h3: r = amt[5] ? 32'h0000_0000 : src << amt[4:0];
      3'h4: r = amt[5] ? 32'h0000_0000 : src >> amt[4:0];
      3'h5, 3'h6: begin
        r = $signed(src) >>> n;
        m_exc[0] = c;
      end
      default: r = dst;
    endcase
    if (rec && op != 3'h7)
      m_cond = {r[31], ~r[31] & (|r), ~(|r), xr[2]};
    m_dest = r;
    wr(irsu_pkg::OFF_SOURCE, src);
    wr(irsu_pkg::OFF_AMOUNT, {26'h0, amt});
    wr(irsu_pkg::OFF_DEST, dst);
    wr(irsu_pkg::OFF_EXC, {29'h0, xr});
    wr(irsu_pkg::OFF_CTRL, {13'h0, mend, mbeg, imm, rec, op});
    @(negedge pclk);
    check("dest", m_dest, dest_value);
    check("carry", {31'h0, m_exc[0]}, {31'h0, carry});
    check("cond", {28'h0, m_cond}, {28'h0, cond});
    rd_chk("exc", irsu_pkg::OFF_EXC, {29'h0, m_exc}, 1'b0);
    rd_chk("dest read", irsu_pkg::OFF_DEST, m_dest, 1'b0);
    $display("test op %0d rec %0b done", op, rec);
  endtask : run_op
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // clock, watchdog and test sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    tally_and_finish;
  end
  initial begin
    presetn = 1'b0;
    num_errors = 0;
    total_checks = 0;
    m_cond = 4'h0;
    repeat (12) @(posedge pclk);
    check("dest rst", irsu_pkg::DATA_RST, dest_value);
    presetn <= 1'b1;
    rd_chk("source rst", irsu_pkg::OFF_SOURCE, irsu_pkg::DATA_RST, 1'b0);
    rd_chk("ctrl rst", irsu_pkg::OFF_CTRL, {13'h0, irsu_pkg::CTRL_RST}, 1'b0);
    rd_chk("exc rst", irsu_pkg::OFF_EXC, {29'h0, irsu_pkg::EXC_RST}, 1'b0);
    rd_chk("unmapped", 8'h20, 32'h0000_0000, 1'b1);
    wr(irsu_pkg::OFF_COND, 32'h0000_000F);
    rd_chk("cond ro", irsu_pkg::OFF_COND, 32'h0000_0000, 1'b0);
    $display("test reset and refusals done");
    run_op(3'h0, 1'b1, 32'h8000_0001, 6'h21, 32'h0, 5'h00, 5'h00, 5'h1F, 3'h4);
    run_op(3'h1, 1'b0, 32'h1234_5678, 6'h00, 32'h0, 5'h08, 5'h1C, 5'h03, 3'h0);
    run_op(3'h2, 1'b1, 32'h0000_00FF, 6'h00, 32'hAAAA_AAAA, 5'h04, 5'h14, 5'h1B, 3'h0);
    run_op(3'h3, 1'b1, 32'hF000_000F, 6'h1F, 32'h0, 5'h00, 5'h00, 5'h00, 3'h3);
    run_op(3'h3, 1'b1, 32'hFFFF_FFFF, 6'h20, 32'h0, 5'h00, 5'h00, 5'h00, 3'h0);
    run_op(3'h4, 1'b1, 32'h8000_0010, 6'h04, 32'h0, 5'h00, 5'h00, 5'h00, 3'h1);
    run_op(3'h4, 1'b0, 32'hFFFF_FFFF, 6'h3F, 32'h0, 5'h00, 5'h00, 5'h00, 3'h0);
    run_op(3'h5, 1'b1, 32'h8000_0018, 6'h00, 32'h0, 5'h04, 5'h00, 5'h00, 3'h6);
    run_op(3'h5, 1'b1, 32'h8000_0010, 6'h00, 32'h0, 5'h04, 5'h00, 5'h00, 3'h1);
    run_op(3'h5, 1'b1, 32'h8000_0001, 6'h00, 32'h0, 5'h00, 5'h00, 5'h00, 3'h1);
    run_op(3'h3, 1'b0, 32'h8000_0003, 6'h01, 32'h0, 5'h00, 5'h00, 5'h00, 3'h0);
    run_op(3'h4, 1'b1, 32'h8000_0003, 6'h01, 32'h0, 5'h00, 5'h00, 5'h00, 3'h4);
    run_op(3'h5, 1'b1, 32'h8000_0003, 6'h00, 32'h0, 5'h01, 5'h00, 5'h00, 3'h0);
    run_op(3'h6, 1'b1, 32'h7000_00FF, 6'h08, 32'h0, 5'h00, 5'h00, 5'h00, 3'h1);
    run_op(3'h6, 1'b1, 32'hFFFF_FFFF, 6'h00, 32'h0, 5'h00, 5'h00, 5'h00, 3'h5);
    run_op(3'h6, 1'b1, 32'h8000_0000, 6'h20, 32'h0, 5'h00, 5'h00, 5'h00, 3'h0);
    run_op(3'h6, 1'b1, 32'h4000_0000, 6'h21, 32'h0, 5'h00, 5'h00, 5'h00, 3'h1);
    run_op(3'h7, 1'b1, 32'h1234_5678, 6'h03, 32'h5555_0000, 5'h01, 5'h02, 5'h03, 3'h1);
    rd_chk("ctrl", irsu_pkg::OFF_CTRL, {13'h0, 5'h03, 5'h02, 5'h01, 1'b1, 3'h7}, 1'b0);
    tally_and_finish;
  end
endmodule : test_integer_rotate_shift_unit
`default_nettype wire
